// ===== pkg/thap_consts.svh
/*
 Register offsets, field positions, reset values and timing figures
 for the thermal alarm pin controller. Assumes one 250 MHz clock.
*/
`ifndef THAP_CONSTS_SVH
`define THAP_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define THAP_A_MANUAL   8'h10
`define THAP_A_HYST     8'h11
`define THAP_A_LIM_R1   8'h6A
`define THAP_A_LIM_LOC  8'h6B
`define THAP_A_LIM_R2   8'h6C
`define THAP_A_MASK1    8'h74
`define THAP_A_MASK2    8'h75
`define THAP_A_CFG3     8'h78
`define THAP_A_TIMER    8'h79
`define THAP_A_TLIM     8'h7A
`define THAP_A_CHEN     8'h7C
`define THAP_A_PINCFG   8'h7D
`define THAP_A_STATUS   8'h80
`define THAP_A_FREQ     8'h81

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define THAP_B_TIMER_EN   1
`define THAP_B_FULL_SPEED 2
`define THAP_B_PIN_DIS    2
`define THAP_B_USE_MAX    3
`define THAP_B_MAN_FULL_SPEED_ON_ALARM  3
`define THAP_B_HYST_OFF   0
`define THAP_B_MASK1      0
`define THAP_B_MASK2      5
`define THAP_B_FLAG       5
`define THAP_B_CH_LO      5
`define THAP_B_FREQ_HI    3
`define THAP_PIN14_ALARM  2'h1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define THAP_RST_CFG    8'h00
`define THAP_RST_LIM    8'hFF
`define THAP_RST_TLIM   8'h00
`define THAP_DUTY_FULL  8'hFF
`define THAP_DUTY_OFF   8'h00
`define THAP_TIMER_FULL 8'hFF
`define THAP_OFF64_MIN  8'h01
`define THAP_TWOS_MIN   8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define THAP_CLK_MHZ    250
`define THAP_TIMER_RES_US 22760
`define THAP_TICK_CYC   (`THAP_TIMER_RES_US * `THAP_CLK_MHZ)

`endif

// ===== pkg/thap_pkg.sv
/*
 Types shared by the thermal alarm pin controller.
 Assumes thap_consts.svh for all numeric figures.
*/
package thap_pkg;

  typedef logic [2:0][7:0] thap_duty_t;

  // Temperature sample, 8.2 fixed point per channel
  typedef struct packed {
    logic            done;
    logic            offset64;
    logic [2:0][9:0] temp;
  } thap_meas_t;

  typedef struct packed {
    thap_duty_t duty;
    logic [7:0] max_duty;
    logic       manual;
  } thap_fan_t;

  typedef enum logic [2:0] {
    THAP_IDLE  = 3'b001,
    THAP_HELD  = 3'b010,
    THAP_FULL_SPEED_ON_ALARM = 3'b100
  } thap_in_st_t;

endpackage

// ===== verilog/thap_tick_div.sv
/*
 Enable-gated divider that produces one-cycle tick pulses.
 Assumes a single clock; the count is kept while enable is low.
*/
module thap_tick_div #(
  parameter int unsigned CYC = 16
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic en_i,
  input  wire logic clr_i,
  output logic      tick_o
);

  logic [31:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || clr_i) begin
      cnt_r  <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (en_i) begin
      if (cnt_r == CYC - 1) begin
        cnt_r  <= 32'h0000_0000;
        tick_o <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 32'h0000_0001;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule

// ===== verilog/thap_ctrl.sv
/*
 Thermal alarm pin controller: input timer, limit flag, fan full_speed_on_alarm and
 critical temperature output drive, with its register file.
 Assumes a register port from the serial slave engine, a sample
 strobe per monitoring cycle and fan duty values from the fan loop.
*/
// Summary of operation
// - Timer monitoring runs only with the enable bit set; off after reset.
// - Shared pin carries alarm whenever the enable bit is set; its function only picks the mask.
// - Full-speed bit drives all running fans to full or programmed maximum duty while asserted.
// - With full-speed bit clear, fan duties pass through unchanged.
// - Fans stopped when the alarm starts are not raised.
// - Matching mask bit suppresses the time-limit alert; the flag still sets.
// - A zero time limit flags on the very first assertion.
// - Enabled channel drives pin low once temperature passes limit by 0.25.
// - Output stays low while above limit; released at or below it.
// - Output changes only at monitoring cycle ends, when a channel is disabled, or when the drive is enabled or disabled.
// - Three critical limits: remote 1, local, remote 2 at consecutive offsets.
// - Three enable bits select which channels may drive the output.
// - Limit at the lowest code disables that channel's output.
// - Hysteresis-off bit only gates the pin drive; the comparison has no hysteresis.
// - Hysteresis on plus alarm-disable bit: pin is never driven.
// - Hysteresis off plus alarm-disable bit: pin is still driven.
// - Alarm and hysteresis both on: output works normally.
// - In manual mode full_speed_on_alarm needs the manual-full_speed_on_alarm bit.
// - A select bit chooses full duty or programmed maximum duty.
// - The alarm-disable bit keeps alarm events from touching fan duty.
// - Drive frequency is one of several low settings or one high setting.
// - Timer accumulates across assertions and saturates at full scale.
// - Reading the timer clears it to zero, or sets it to one while the input is asserted.
// - Eight-bit time limit spans first assertion up to full scale.
`include "thap_consts.svh"
module thap_ctrl import thap_pkg::*; #(
  parameter int unsigned TICK_CYC = `THAP_TICK_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  input  wire logic       alarm_pin_n_i,
  output logic            alarm_pin_out_o,
  output logic            alarm_pin_oe_n_o,
  input  wire thap_meas_t meas_i,
  input  wire thap_fan_t  fan_i,
  output thap_duty_t      fan_duty_o,
  output logic [3:0]      drive_freq_o,
  output logic            alarm_time_limit_flag_o,
  output logic            alert_o
);

  function automatic logic [7:0] norm(input logic [7:0] v, input logic off64);
    norm = off64 ? v : (v ^ 8'h80);
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] man_r, hyst_r, mask1_r, mask2_r, cfg3_r, tlim_r;
  logic [7:0] chen_r, pincfg_r, freq_r, timer_r;
  logic [2:0][7:0] lim_r;
  logic flag_r, flag_set, timer_rd;
  logic pin_s1_r, pin_s2_r;
  logic asserted;

  assign timer_rd = reg_rd_i && (reg_addr_i == `THAP_A_TIMER);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      man_r    <= `THAP_RST_CFG;
      hyst_r   <= `THAP_RST_CFG;
      mask1_r  <= `THAP_RST_CFG;
      mask2_r  <= `THAP_RST_CFG;
      cfg3_r   <= `THAP_RST_CFG;
      tlim_r   <= `THAP_RST_TLIM;
      chen_r   <= `THAP_RST_CFG;
      pincfg_r <= `THAP_RST_CFG;
      freq_r   <= `THAP_RST_CFG;
      lim_r    <= {3{`THAP_RST_LIM}};
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `THAP_A_MANUAL:  man_r    <= reg_wdata_i;
        `THAP_A_HYST:    hyst_r   <= reg_wdata_i;
        `THAP_A_LIM_R1:  lim_r[0] <= reg_wdata_i;
        `THAP_A_LIM_LOC: lim_r[1] <= reg_wdata_i;
        `THAP_A_LIM_R2:  lim_r[2] <= reg_wdata_i;
        `THAP_A_MASK1:   mask1_r  <= reg_wdata_i;
        `THAP_A_MASK2:   mask2_r  <= reg_wdata_i;
        `THAP_A_CFG3:    cfg3_r   <= reg_wdata_i;
        `THAP_A_TLIM:    tlim_r   <= reg_wdata_i;
        `THAP_A_CHEN:    chen_r   <= reg_wdata_i;
        `THAP_A_PINCFG:  pincfg_r <= reg_wdata_i;
        `THAP_A_FREQ:    freq_r   <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `THAP_A_MANUAL:  reg_rdata_o <= man_r;
        `THAP_A_HYST:    reg_rdata_o <= hyst_r;
        `THAP_A_LIM_R1:  reg_rdata_o <= lim_r[0];
        `THAP_A_LIM_LOC: reg_rdata_o <= lim_r[1];
        `THAP_A_LIM_R2:  reg_rdata_o <= lim_r[2];
        `THAP_A_MASK1:   reg_rdata_o <= mask1_r;
        `THAP_A_MASK2:   reg_rdata_o <= mask2_r;
        `THAP_A_CFG3:    reg_rdata_o <= cfg3_r;
        `THAP_A_TIMER:   reg_rdata_o <= timer_r;
        `THAP_A_TLIM:    reg_rdata_o <= tlim_r;
        `THAP_A_CHEN:    reg_rdata_o <= chen_r;
        `THAP_A_PINCFG:  reg_rdata_o <= pincfg_r;
        `THAP_A_STATUS:  reg_rdata_o <= {2'b00, flag_r, 3'b000,
                                         ~alarm_pin_oe_n_o, asserted};
        `THAP_A_FREQ:    reg_rdata_o <= freq_r;
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin input and cumulative timer
  // ----------------------------------------------------------------
  logic pin_en, tick, ast_rise;
  logic asserted_q;

  assign pin_en   = cfg3_r[`THAP_B_TIMER_EN];
  assign asserted = pin_en && !pin_s2_r;
  assign ast_rise = asserted && !asserted_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_s1_r   <= 1'b1;
      pin_s2_r   <= 1'b1;
      asserted_q <= 1'b0;
    end else begin
      pin_s1_r   <= alarm_pin_n_i;
      pin_s2_r   <= pin_s1_r;
      asserted_q <= asserted;
    end
  end

  thap_tick_div #(
    .CYC (TICK_CYC)
  ) u_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .en_i      (asserted),
    .clr_i     (timer_rd),
    .tick_o    (tick)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_r <= 8'h00;
    end else if (timer_rd) begin
      timer_r <= {7'h00, asserted};
    end else if (ast_rise && timer_r == 8'h00) begin
      timer_r <= 8'h01;
    end else if (tick && timer_r != `THAP_TIMER_FULL) begin
      timer_r <= timer_r + 8'h01;
    end
  end

  // Set wins over a same-cycle write-one clear
  assign flag_set = (asserted && tlim_r == 8'h00) || (timer_r > tlim_r);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_r <= 1'b0;
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `THAP_A_STATUS
                 && reg_wdata_i[`THAP_B_FLAG]) begin
      flag_r <= 1'b0;
    end
  end

  logic masked;
  assign masked = (pincfg_r[1:0] == `THAP_PIN14_ALARM) ? mask2_r[`THAP_B_MASK2]
                                                      : mask1_r[`THAP_B_MASK1];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alarm_time_limit_flag_o <= 1'b0;
      alert_o                 <= 1'b0;
    end else begin
      alarm_time_limit_flag_o <= flag_r;
      alert_o                 <= flag_r && !masked;
    end
  end

  // ----------------------------------------------------------------
  // Fan full_speed_on_alarm on asserted input
  // ----------------------------------------------------------------
  thap_in_st_t st_r;
  logic [2:0]  run_r;
  logic        full_speed_on_alarm_ok;
  logic [7:0]  full_speed_on_alarm_duty;

  assign full_speed_on_alarm_ok = cfg3_r[`THAP_B_FULL_SPEED]
                    && !pincfg_r[`THAP_B_PIN_DIS]
                    && (!fan_i.manual || man_r[`THAP_B_MAN_FULL_SPEED_ON_ALARM]);
  assign full_speed_on_alarm_duty = pincfg_r[`THAP_B_USE_MAX] ? fan_i.max_duty
                                                : `THAP_DUTY_FULL;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r  <= THAP_IDLE;
      run_r <= 3'b000;
    end else begin
      unique case (st_r)
        THAP_IDLE: begin
          if (asserted) begin
            // Latch which fans were running at assertion
            for (int i = 0; i < 3; i++) begin
              run_r[i] <= fan_i.duty[i] != `THAP_DUTY_OFF;
            end
            st_r <= full_speed_on_alarm_ok ? THAP_FULL_SPEED_ON_ALARM : THAP_HELD;
          end
        end
        THAP_HELD: begin
          if (!asserted) begin
            st_r <= THAP_IDLE;
          end else if (full_speed_on_alarm_ok) begin
            st_r <= THAP_FULL_SPEED_ON_ALARM;
          end
        end
        THAP_FULL_SPEED_ON_ALARM: begin
          if (!asserted) begin
            st_r <= THAP_IDLE;
          end else if (!full_speed_on_alarm_ok) begin
            st_r <= THAP_HELD;
          end
        end
        default: st_r <= THAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fan_duty_o <= {3{`THAP_DUTY_OFF}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        fan_duty_o[i] <= (st_r == THAP_FULL_SPEED_ON_ALARM && run_r[i] && full_speed_on_alarm_ok)
                         ? full_speed_on_alarm_duty : fan_i.duty[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      drive_freq_o <= 4'h0;
    end else if (freq_r[`THAP_B_FREQ_HI]) begin
      drive_freq_o <= 4'h8;
    end else begin
      drive_freq_o <= {1'b0, freq_r[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // Critical temperature output
  // ----------------------------------------------------------------
  logic [2:0] over_r;
  logic       out_allow;
  logic [2:0] ch_ok;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ch_ok[i] = chen_r[`THAP_B_CH_LO + i]
                 && (meas_i.offset64 ? lim_r[i] > `THAP_OFF64_MIN
                                     : lim_r[i] != `THAP_TWOS_MIN);
    end
  end

  // Pin stays released with alarm-disable set unless hysteresis is off
  assign out_allow = pin_en && (!pincfg_r[`THAP_B_PIN_DIS]
                     || hyst_r[`THAP_B_HYST_OFF]);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      over_r <= 3'b000;
    end else if (meas_i.done) begin
      for (int i = 0; i < 3; i++) begin
        // Set at limit plus a quarter degree or above, clear at or below limit
        over_r[i] <= ch_ok[i] && ({norm(meas_i.temp[i][9:2], meas_i.offset64),
                     meas_i.temp[i][1:0]} > {norm(lim_r[i], meas_i.offset64),
                     2'b00});
      end
    end else begin
      over_r <= over_r & ch_ok;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alarm_pin_out_o  <= 1'b1;
      alarm_pin_oe_n_o <= 1'b1;
    end else begin
      alarm_pin_out_o  <= 1'b0;
      alarm_pin_oe_n_o <= !(out_allow && |over_r);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic done_q;
  always_ff @(posedge clk_i) begin
    done_q <= meas_i.done;
  end

  property p_off_no_drive;
    @(posedge clk_i) disable iff (sys_rst_i)
      !cfg3_r[`THAP_B_TIMER_EN] |=> alarm_pin_oe_n_o;
  endproperty
  a_off_no_drive: assert property (p_off_no_drive)
    else $error("pin driven while alarm function off");

  property p_zero_limit;
    @(posedge clk_i) disable iff (sys_rst_i)
      ast_rise && tlim_r == 8'h00 |-> ##[1:2] alarm_time_limit_flag_o;
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("zero limit did not flag first assertion");

  property p_mask;
    @(posedge clk_i) disable iff (sys_rst_i)
      masked |=> !alert_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("alert not masked");

  property p_no_full_speed_on_alarm;
    @(posedge clk_i) disable iff (sys_rst_i)
      !cfg3_r[`THAP_B_FULL_SPEED] |=> fan_duty_o == $past(fan_i.duty);
  endproperty
  a_no_full_speed_on_alarm: assert property (p_no_full_speed_on_alarm)
    else $error("fan duty changed with full-speed off");

  property p_full_speed_on_alarm;
    @(posedge clk_i) disable iff (sys_rst_i)
      st_r == THAP_FULL_SPEED_ON_ALARM && full_speed_on_alarm_ok && run_r[0] && !pincfg_r[`THAP_B_USE_MAX]
      |=> fan_duty_o[0] == `THAP_DUTY_FULL;
  endproperty
  a_full_speed_on_alarm: assert property (p_full_speed_on_alarm)
    else $error("running fan not at full duty");

  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(alarm_pin_oe_n_o) |-> $past(done_q) || !$past(out_allow)
                                  || |($past(over_r, 2) & ~$past(ch_ok, 2));
  endproperty
  a_hold: assert property (p_hold)
    else $error("output released outside a monitoring cycle end");

  property p_read_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      timer_rd |=> timer_r <= 8'h01;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("timer not cleared on read");

  property p_saturate;
    @(posedge clk_i) disable iff (sys_rst_i)
      timer_r == `THAP_TIMER_FULL && !timer_rd |=> timer_r == `THAP_TIMER_FULL;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("timer left full scale without a read");

  property p_reset;
    @(posedge clk_i) sys_rst_i |=> alarm_pin_oe_n_o && timer_r == 8'h00;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not clean after reset");

  c_full_speed_on_alarm: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r == THAP_FULL_SPEED_ON_ALARM);
  c_drive: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(alarm_pin_oe_n_o));
  c_alert: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(alert_o));

endmodule

// ===== tb/thap_far_model.sv
/*
 Far-side model: processor hot signal sharing the open-drain alarm pin.
 Assumes a pull-up on the wire; the bench commands when it asserts.
*/
module thap_far_model (
  input  wire logic       clk_i,
  input  wire logic       hot_i,
  input  wire logic [1:0] lag_i,
  input  wire logic       dev_out_i,
  input  wire logic       dev_oe_n_i,
  output logic            pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] hot_r = 4'h0;

  // Command delayed by one to four cycles
  always_ff @(posedge clk_i) begin
    hot_r <= {hot_r[2:0], hot_i};
  end

  // Wire low when either side pulls, else pull-up
  assign pin_n_o = !(hot_r[lag_i] || (!dev_oe_n_i && !dev_out_i));
endmodule

// ===== tb/thermal_alarm_pin_control_tb.sv
/*
 Self-checking bench for the thermal alarm pin controller.
 Assumes the design package and constants header on the include path.
*/
`include "thap_consts.svh"
module thermal_alarm_pin_control_tb import thap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       hot_i = 1'b0;
  logic [1:0] lag_i = 2'h0;
  logic       pin_n;
  logic       pin_out;
  logic       oe_n;
  thap_meas_t meas_i = '0;
  thap_fan_t  fan_i = '0;
  thap_duty_t fan_duty_o;
  logic [3:0] drive_freq_o;
  logic       flag;
  logic       alert;
  int         failures = 0;
  int         checks = 0;
  int         seed = 32'hDF1CF516;

  thap_ctrl #(.TICK_CYC(8)) u_thap_ctrl (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .alarm_pin_n_i(pin_n), .alarm_pin_out_o(pin_out),
    .alarm_pin_oe_n_o(oe_n), .meas_i(meas_i), .fan_i(fan_i), .fan_duty_o(fan_duty_o),
    .drive_freq_o(drive_freq_o), .alarm_time_limit_flag_o(flag), .alert_o(alert));

  thap_far_model u_thap_far_model (
    .clk_i(clk_i), .hot_i(hot_i), .lag_i(lag_i), .dev_out_i(pin_out),
    .dev_oe_n_i(oe_n), .pin_n_o(pin_n));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk("register", 24'(exp), 24'(d));
  endtask

  task automatic on;
    @(posedge clk_i);
    lag_i <= 2'($random(seed));
    hot_i <= 1'b1;
  endtask

  task automatic off;
    @(posedge clk_i);
    hot_i <= 1'b0;
    cyc(6);
  endtask

  task automatic samp(input int c, input logic [9:0] t);
    logic [2:0][9:0] tv;
    tv = {3{10'h200}}; // Other channels at the lowest code
    tv[c] = t;
    @(posedge clk_i);
    meas_i.temp <= tv;
    meas_i.done <= 1'b1;
    @(posedge clk_i);
    meas_i.done <= 1'b0;
    cyc(3);
  endtask

  function automatic thap_duty_t exp_duty(logic [7:0] c3, logic [7:0] pc, logic [7:0] mn,
                                          thap_fan_t f);
    logic       ok;
    thap_duty_t r;
    ok = c3[`THAP_B_FULL_SPEED] && !pc[`THAP_B_PIN_DIS] && (!f.manual || mn[`THAP_B_MAN_FULL_SPEED_ON_ALARM]);
    r = f.duty;
    for (int i = 0; i < 3; i++) begin
      if (ok && f.duty[i] != `THAP_DUTY_OFF)
        r[i] = pc[`THAP_B_USE_MAX] ? f.max_duty : `THAP_DUTY_FULL;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v, c3, pc, mn, lim, en, hy, rv;
    logic [7:0] ad [10];
    thap_fan_t  f;
    logic       dv;
    ad = '{`THAP_A_MANUAL, `THAP_A_HYST, `THAP_A_LIM_R1, `THAP_A_LIM_LOC, `THAP_A_LIM_R2,
           `THAP_A_MASK1, `THAP_A_MASK2, `THAP_A_CFG3, `THAP_A_CHEN, `THAP_A_PINCFG};
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cyc(2);
    chk("oe_n", 24'(1'b1), 24'(oe_n));
    chk("pin_out", 24'(1'b0), 24'(pin_out));
    rdck(`THAP_A_TIMER, 8'h00);
    for (int i = 0; i < 10; i++) begin
      rv = (i >= 2 && i <= 4) ? `THAP_RST_LIM : `THAP_RST_CFG;
      v = 8'($random(seed));
      rdck(ad[i], rv);
      wr(ad[i], v);
      rdck(ad[i], v);
      wr(ad[i], rv);
    end
    wr(8'h55, 8'hA5);
    rdck(8'h55, 8'h00);
    wr(`THAP_A_TIMER, 8'h5A);
    rdck(`THAP_A_TIMER, 8'h00);
    wr(`THAP_A_FREQ, 8'h0B);
    cyc(2);
    chk("freq", 24'(4'h8), 24'(drive_freq_o));
    wr(`THAP_A_FREQ, 8'h05);
    cyc(2);
    chk("freq", 24'(4'h5), 24'(drive_freq_o));
    on();
    cyc(30);
    off();
    rdck(`THAP_A_TIMER, 8'h00);
    chk("flag", 24'(1'b0), 24'(flag));
    wr(`THAP_A_CFG3, 8'h02);
    wr(`THAP_A_TLIM, 8'h00);
    on();
    cyc(10);
    chk("flag", 24'(1'b1), 24'(flag));
    chk("alert", 24'(1'b1), 24'(alert));
    cyc(30);
    off();
    on();
    cyc(40);
    off();
    rd(`THAP_A_TIMER, v);
    chk("timer span", 24'(1'b1), 24'(v >= 8'h09 && v <= 8'h0C));
    rdck(`THAP_A_TIMER, 8'h00);
    on();
    cyc(2200);
    off();
    rdck(`THAP_A_TIMER, `THAP_TIMER_FULL);
    wr(`THAP_A_STATUS, 8'h20);
    wr(`THAP_A_TLIM, 8'h03);
    cyc(2);
    chk("flag", 24'(1'b0), 24'(flag));
    on();
    cyc(12);
    chk("flag", 24'(1'b0), 24'(flag));
    cyc(40);
    chk("flag", 24'(1'b1), 24'(flag));
    off();
    wr(`THAP_A_TLIM, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(`THAP_A_PINCFG, m ? 8'h01 : 8'h00);
      wr(`THAP_A_MASK2, m ? 8'h20 : 8'h00);
      wr(`THAP_A_MASK1, m ? 8'h00 : 8'h01);
      rd(`THAP_A_TIMER, v);
      wr(`THAP_A_STATUS, 8'h20);
      on();
      cyc(10);
      off();
      chk("flag", 24'(1'b1), 24'(flag));
      chk("alert", 24'(1'b0), 24'(alert));
      wr(m ? `THAP_A_MASK2 : `THAP_A_MASK1, 8'h00);
      cyc(3);
      chk("alert", 24'(1'b1), 24'(alert));
    end
    wr(`THAP_A_PINCFG, 8'h00);
    for (int i = 0; i < 16; i++) begin
      c3 = 8'h02 | (8'($random(seed)) & 8'h04);
      pc = 8'($random(seed)) & 8'h0C;
      mn = 8'($random(seed)) & 8'h08;
      f = thap_fan_t'(33'($random(seed) ^ ($random(seed) << 8)));
      f.duty[i % 3] = `THAP_DUTY_OFF;
      if (i < 2) begin
        c3 = 8'h06;
        pc = (i == 1) ? 8'h08 : 8'h00;
      end
      wr(`THAP_A_CFG3, c3);
      wr(`THAP_A_PINCFG, pc);
      wr(`THAP_A_MANUAL, mn);
      fan_i <= f;
      cyc(3);
      chk("duty idle", f.duty, fan_duty_o);
      on();
      cyc(10);
      chk("duty full_speed_on_alarm", exp_duty(c3, pc, mn, f), fan_duty_o);
      off();
    end
    wr(`THAP_A_CFG3, 8'h02);
    for (int k = 0; k < 9; k++) begin
      en = (8'($random(seed)) & 8'hE0) | (8'h20 << (k % 3));
      pc = 8'($random(seed)) & 8'h04;
      hy = 8'($random(seed)) & 8'h01;
      lim = 8'h40 + (8'($random(seed)) & 8'h1F);
      dv = !(pc[`THAP_B_PIN_DIS] && !hy[`THAP_B_HYST_OFF]);
      wr(`THAP_A_CHEN, en);
      wr(`THAP_A_PINCFG, pc);
      wr(`THAP_A_HYST, hy);
      wr(`THAP_A_LIM_R1 + 8'(k % 3), lim);
      samp(k % 3, {lim, 2'b00});
      chk("oe_n", 24'(1'b1), 24'(oe_n));
      samp(k % 3, {lim, 2'b01});
      chk("oe_n", 24'(!dv), 24'(oe_n));
      cyc(20);
      chk("oe_n", 24'(!dv), 24'(oe_n));
      samp(k % 3, {lim, 2'b11});
      chk("oe_n", 24'(!dv), 24'(oe_n));
      samp(k % 3, {lim, 2'b00});
      chk("oe_n", 24'(1'b1), 24'(oe_n));
      wr(`THAP_A_LIM_R1 + 8'(k % 3), 8'hFF);
    end
    wr(`THAP_A_CHEN, 8'hE0);
    wr(`THAP_A_PINCFG, 8'h00);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_i);
      meas_i.offset64 <= 1'(j);
      wr(`THAP_A_LIM_LOC, j ? `THAP_OFF64_MIN : `THAP_TWOS_MIN);
      samp(1, 10'h3FF);
      chk("oe_n", 24'(1'b1), 24'(oe_n));
    end
    results();
  end

  initial begin
    #(4 * 40000);
    failures++;
    results();
  end
endmodule
